// >>> sbor_consts.vh
// Purpose: Constants for the serial bus options register block.
// Assumes: Included by sbor_serial_bus_options_register.v only.
// Notes:   Byte offsets are Wishbone byte addresses of aligned 32-bit words.
`ifndef SBOR_CONSTS_VH
`define SBOR_CONSTS_VH
`define SBOR_ADDR_W          8
`define SBOR_OFF_BUS_OPTIONS 8'h20
`define SBOR_OFF_ROM_CTRL    8'h60
`define SBOR_OFF_RX_CHECK    8'h64
`define SBOR_BIT_IRMC        31
`define SBOR_BIT_CMC         30
`define SBOR_BIT_ISC         29
`define SBOR_BIT_BMC         28
`define SBOR_BIT_PMC         27
`define SBOR_CAP_HI          31
`define SBOR_CAP_LO          27
`define SBOR_ACC_HI          23
`define SBOR_ACC_LO          16
`define SBOR_REC_HI          15
`define SBOR_REC_LO          12
`define SBOR_GEN_HI          7
`define SBOR_GEN_LO          6
`define SBOR_SPD_HI          2
`define SBOR_SPD_LO          0
`define SBOR_CAP_RESET       5'h00
`define SBOR_ACC_RESET       8'h00
`define SBOR_REC_RESET       4'ha
`define SBOR_REC_MIN         4'h8
`define SBOR_GEN_RESET       2'h0
`define SBOR_GEN_ONE         2'h1
`define SBOR_SPD_CODE        3'h2
`define SBOR_LEN_W           17
`define SBOR_LEN_ONE         17'h00001
`define SBOR_ZERO32          32'h00000000
`endif

// >>> sbor_serial_bus_options_register.v
// Purpose: Bus options register, Wishbone slave, mirrored as bus info quadlet two.
// Assumes: Classic Wishbone, 32-bit data, one-cycle ack, synchronous inputs.
// Notes:   Ack rises the cycle after cyc and stb and drops for one cycle after.
//
// Overview of operation
// - Bus options register at byte offset 20h, also mirrored as bus info quadlet.
// - Bits 31..27 are writable capability flags irmc, cmc, isc, bmc, pmc.
// - Power management capable flag set means node advertises that capability.
// - Bits 23..16 are writable cycle master clock accuracy in ppm.
// - Bits 15..12 give max request size 2^(n+1), never below 512 bytes; smaller codes are kept and clear linkFieldsValid while linkEnableBit is set.
// - Block write longer than max request size may get ack_type_error.
// - Hard reset sets max request to 2048 code; soft reset keeps it.
// - Bits 7..6 writable generation counter, advances on ROM change since bus reset.
// - Bits 2..0 read only, always return 010.
// - Reserved ranges 26..24, 11..8 and 5..3 always read zero.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "sbor_consts.vh"
module sbor_serial_bus_options_register (
    input  wire        core_clk,
    input  wire        nrst,
    input  wire        softReset,
    input  wire        linkEnableBit,
    input  wire        romChanged,
    input  wire        busReset,
    input  wire        rxBlockWrite,
    input  wire [16:0] rxLength,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg  [31:0] busInfoQuadlet,
    output reg         pmCapable,
    output reg         ackTypeError,
    output reg         linkFieldsValid
);

    reg  [4:0]  capFlags_reg;
    reg  [7:0]  clkAccuracy_reg;
    reg  [3:0]  maxRec_reg;
    reg  [1:0]  generation_reg;
    reg         romDirty_reg;
    reg         typeErrEnable_reg;
    reg  [15:0] typeErrCount_reg;

    wire        request;
    wire        writeStrobe;
    wire        hitOptions;
    wire        hitRomCtrl;
    wire        hitRxCheck;
    wire [31:0] optionsWord;
    wire [`SBOR_LEN_W-1:0] maxRecBytes;
    wire        oversize;

    assign request     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign writeStrobe = request & wb_we_i;
    assign hitOptions  = (wb_adr_i == `SBOR_OFF_BUS_OPTIONS);
    assign hitRomCtrl  = (wb_adr_i == `SBOR_OFF_ROM_CTRL);
    assign hitRxCheck  = (wb_adr_i == `SBOR_OFF_RX_CHECK);

    // Reserved bits are wired to zero and the speed code is a constant, so no
    // flip-flop can ever make them read otherwise.
    assign optionsWord = {capFlags_reg,
                          3'h0,
                          clkAccuracy_reg,
                          maxRec_reg,
                          4'h0,
                          generation_reg,
                          3'h0,
                          `SBOR_SPD_CODE};

    // Size in bytes is two to the power of the field plus one.
    // The exponent is widened to five bits so that code 15 cannot wrap to 0.
    assign maxRecBytes = `SBOR_LEN_ONE << ({1'b0, maxRec_reg} + 5'h01);
    assign oversize    = rxBlockWrite & (rxLength > maxRecBytes);

    // Capability, accuracy and generation fields: only the sel lanes that
    // carry them are written; max request is written in its own block, all other bit positions ignore writes.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            capFlags_reg    <= `SBOR_CAP_RESET;
            clkAccuracy_reg <= `SBOR_ACC_RESET;
            generation_reg  <= `SBOR_GEN_RESET;
            romDirty_reg    <= 1'b0;
        end else if (softReset) begin
            capFlags_reg    <= `SBOR_CAP_RESET;
            clkAccuracy_reg <= `SBOR_ACC_RESET;
            generation_reg  <= `SBOR_GEN_RESET;
            romDirty_reg    <= 1'b0;
        end else begin
            if (writeStrobe && hitOptions && wb_sel_i[3]) begin
                capFlags_reg <= wb_dat_i[`SBOR_CAP_HI:`SBOR_CAP_LO];
            end
            if (writeStrobe && hitOptions && wb_sel_i[2]) begin
                clkAccuracy_reg <= wb_dat_i[`SBOR_ACC_HI:`SBOR_ACC_LO];
            end
            // A software write wins over the automatic advance in one cycle.
            if (writeStrobe && hitOptions && wb_sel_i[0]) begin
                generation_reg <= wb_dat_i[`SBOR_GEN_HI:`SBOR_GEN_LO];
            end else if (busReset && (romDirty_reg || romChanged)) begin
                generation_reg <= generation_reg + `SBOR_GEN_ONE;
            end
            // A bus reset consumes every pending change, including one that
            // arrives in the same cycle, so no change is counted twice.
            if (busReset) begin
                romDirty_reg <= 1'b0;
            end else if (romChanged) begin
                romDirty_reg <= 1'b1;
            end
        end
    end

    // Max request survives soft reset; only the hard reset reloads it.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            maxRec_reg <= `SBOR_REC_RESET;
        end else if (writeStrobe && hitOptions && wb_sel_i[1]) begin
            maxRec_reg <= wb_dat_i[`SBOR_REC_HI:`SBOR_REC_LO];
        end
    end

    // Control word at 60h: bit 0 enables type error answers to oversize writes.
    // Counter at 64h counts oversize writes seen; any write clears it, but an
    // oversize event in the same cycle wins over the clear.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            typeErrEnable_reg <= 1'b0;
            typeErrCount_reg  <= 16'h0000;
        end else begin
            if (writeStrobe && hitRomCtrl && wb_sel_i[0]) begin
                typeErrEnable_reg <= wb_dat_i[0];
            end
            if (oversize) begin
                typeErrCount_reg <= typeErrCount_reg + 16'h0001;
            end else if (writeStrobe && hitRxCheck) begin
                typeErrCount_reg <= 16'h0000;
            end
        end
    end

    // Wishbone answer one cycle after the request; unmapped reads give zero.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `SBOR_ZERO32;
        end else begin
            wb_ack_o <= request;
            if (request && !wb_we_i && hitOptions) begin
                wb_dat_o <= optionsWord;
            end else if (request && !wb_we_i && hitRomCtrl) begin
                wb_dat_o <= {31'h00000000, typeErrEnable_reg};
            end else if (request && !wb_we_i && hitRxCheck) begin
                wb_dat_o <= {16'h0000, typeErrCount_reg};
            end else begin
                wb_dat_o <= `SBOR_ZERO32;
            end
        end
    end

    // Link-side views; software alone keeps the fields valid under link enable.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busInfoQuadlet  <= `SBOR_ZERO32;
            pmCapable       <= 1'b0;
            ackTypeError    <= 1'b0;
            linkFieldsValid <= 1'b0;
        end else begin
            busInfoQuadlet  <= optionsWord;
            pmCapable       <= capFlags_reg[`SBOR_BIT_PMC - `SBOR_CAP_LO];
            ackTypeError    <= oversize & typeErrEnable_reg;
            linkFieldsValid <= ~linkEnableBit | (maxRec_reg >= `SBOR_REC_MIN);
        end
    end

endmodule

// >>> sbor_chk.sv
// Purpose: Port assertions for the bus options register.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Output copies lag the register by one cycle, hence the $past guards.
`timescale 1ns/1ns
module sbor_chk (
    input logic        core_clk, nrst, softReset, linkEnableBit,
    input logic        romChanged, busReset, rxBlockWrite,
    input logic [16:0] rxLength,
    input logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input logic [7:0]  wb_adr_i,
    input logic [31:0] wb_dat_o, busInfoQuadlet,
    input logic        pmCapable, ackTypeError, linkFieldsValid
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire [31:0] q = busInfoQuadlet;
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_speed_code: assert property ($past(nrst) |-> q[2:0] == 3'h2)
        else $error("speed code wrong");
    a_rsvd_zero: assert property ($past(nrst) |-> {q[26:24], q[11:8], q[5:3]} == 10'h000)
        else $error("reserved bits not zero");
    a_pm_flag: assert property ($past(nrst) |-> pmCapable == q[27])
        else $error("power flag differs from bit 27");
    a_read_mirror: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h20 |-> wb_dat_o == q)
        else $error("read data differs from mirror");
    a_max_valid: assert property ($past(nrst) |-> linkFieldsValid == !($past(linkEnableBit) && q[15:12] < 4'h8))
        else $error("request size flag wrong");
    a_oversize_ack: assert property (ackTypeError |-> $past(rxBlockWrite) && $past(rxLength) > (32'h1 << (q[15:12] + 1)))
        else $error("type error without oversize write");
    a_gen_step: assert property (busReset && romChanged && !wb_cyc_i && !softReset |-> ##2 q[7:6] == $past(q[7:6]) + 2'h1)
        else $error("generation did not advance");
    c_read: cover property (wb_ack_o && !wb_we_i);
    c_oversize: cover property (ackTypeError);
    c_gen: cover property (busReset && romChanged);
endmodule
bind sbor_serial_bus_options_register sbor_chk i_chk (.*);

// >>> sbor_node_model.sv
// Purpose: Remote node model that raises bus resets, ROM changes and block writes.
// Assumes: Events change just after a rising clock edge.
// Notes:   The length lines carry junk between packets so stale values never match.
`timescale 1ns/1ns
module sbor_node_model (
    input  logic        core_clk,
    output logic        romChanged = 1'b0,
    output logic        busReset = 1'b0,
    output logic        rxBlockWrite = 1'b0,
    output logic [16:0] rxLength = 17'h1ffff
);
    task busRst(input logic rom);
        @(posedge core_clk);
        busReset <= 1'b1;
        romChanged <= rom;
        @(posedge core_clk);
        busReset <= 1'b0;
        romChanged <= 1'b0;
    endtask
    task send(input logic [16:0] len);
        @(posedge core_clk);
        rxBlockWrite <= 1'b1;
        rxLength <= len;
        @(posedge core_clk);
        rxBlockWrite <= 1'b0;
        rxLength <= ~len;
    endtask
endmodule

// >>> sbor_serial_bus_options_register_tb_top.sv
// Purpose: Self-checking bench for the bus options register.
// Assumes: Slave answers in one cycle; master still waits for ack.
// Notes:   Link events come from the node model.
`timescale 1ns/1ns
module sbor_serial_bus_options_register_tb_top;
    logic        core_clk = 1'b0, nrst = 1'b0, softReset = 1'b0, linkEnableBit = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, busInfoQuadlet;
    logic        wb_ack_o, pmCapable, ackTypeError, linkFieldsValid;
    logic        romChanged, busReset, rxBlockWrite;
    logic [16:0] rxLength;
    int          bad_count = 0, checks_done = 0;
    always #5 core_clk = ~core_clk;
    sbor_node_model i_node (.*);
    sbor_serial_bus_options_register i_dut (.*);
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task bus(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
             output logic [31:0] r);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        @(negedge core_clk);
        while (wb_ack_o !== 1'b1) @(negedge core_clk);
        r = wb_dat_o;
        @(posedge core_clk);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        bus(1'b1, a, d, s, r);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, 4'hf, r);
        chk(r, exp);
    endtask
    task summarize;
        if (bad_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Whole run needs well under a thousand cycles.
    initial begin
        repeat (3000) @(posedge core_clk);
        bad_count++;
        summarize;
    end
    initial begin
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        rd(8'h20, 32'h0000a002);
        wr(8'h20, 32'hffffffff, 4'hf);
        rd(8'h20, 32'hf8fff0c2);
        repeat (2) @(posedge core_clk);
        chk(pmCapable, 32'h1);
        chk(busInfoQuadlet, 32'hf8fff0c2);
        wr(8'h20, 32'h0, 4'h8);
        rd(8'h20, 32'h00fff0c2);
        wr(8'h20, 32'h0, 4'h5);
        rd(8'h20, 32'h0000f002);
        rd(8'h44, 32'h0);
        wr(8'h20, 32'hffffffff, 4'hc);
        softReset <= 1'b1;
        @(posedge core_clk);
        softReset <= 1'b0;
        rd(8'h20, 32'h0000f002);
        i_node.busRst(1'b1);
        rd(8'h20, 32'h0000f042);
        i_node.busRst(1'b0);
        rd(8'h20, 32'h0000f042);
        wr(8'h60, 32'h1, 4'hf);
        wr(8'h20, 32'h00008000, 4'h2);
        linkEnableBit <= 1'b1;
        i_node.send(17'd513);
        @(negedge core_clk);
        chk(ackTypeError, 32'h1);
        i_node.send(17'd512);
        @(negedge core_clk);
        chk(ackTypeError, 32'h0);
        chk(linkFieldsValid, 32'h1);
        rd(8'h64, 32'h00000001);
        wr(8'h20, 32'h00007000, 4'h2);
        repeat (2) @(posedge core_clk);
        chk(linkFieldsValid, 32'h0);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rd(8'h20, 32'h0000a002);
        summarize;
    end
endmodule
